// ===== verilog/rcp_consts.vh
`ifndef RCP_CONSTS_VH
`define RCP_CONSTS_VH

// clock rate and the millisecond tick it gives, sized for the tick counter
`define RCP_CLK_HZ 40000000
`define RCP_MS_CYCLES 16'h9C40

// positions inside the synchronised level vector
`define RCP_SY_RESET_N 0
`define RCP_SY_SLEEP_N 1
`define RCP_SY_HOLD 2
`define RCP_SY_REPLY 3
`define RCP_SY_BIND 4
`define RCP_SY_LOW_DIR 5
`define RCP_SY_HIGH_DIR 6
`define RCP_SY_CMD 7
`define RCP_SY_WIDTH 8
// reset value of the synchronisers: reset and sleep held asserted
`define RCP_SY_RST_VAL 8'h00

// status line groups
`define RCP_STATUS_WIDTH 8
`define RCP_GROUP_WIDTH 4

// factory default request: bind presses within a window
`define RCP_FACTORY_PRESSES 3'h4
`define RCP_SEQ_WINDOW_MS 12'h7D0

// activity indicator flash period and on times per state, in ms
`define RCP_FLASH_PERIOD_MS 10'h3E8
`define RCP_FLASH_IDLE_MS 10'h032
`define RCP_FLASH_ACTIVE_MS 10'h0C8
`define RCP_FLASH_BIND_MS 10'h1F4

`endif

// ===== verilog/rcp_sync.v
`timescale 1ns/1ps
`default_nettype none

module rcp_sync #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      // each bit owns its flop pair, so no vector has several drivers
      reg stage1;
      reg stage2;
      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          stage1 <= RST_VAL[gi];
          stage2 <= RST_VAL[gi];
        end else begin
          stage1 <= i_async[gi];
          stage2 <= stage1;
        end
      end
      assign o_sync[gi] = stage2;
    end
  endgenerate

endmodule // rcp_sync

`default_nettype wire

// ===== verilog/rcp_pin_logic.v
`timescale 1ns/1ps
`default_nettype none
`include "rcp_consts.vh"

// Overview of operation
// RQ1: reset pin low returns everything to initial state; high allows operation.
// RQ2: sleep pin low stops all functions; high resumes normal operation.
// RQ3: hold select high: each activating command toggles the status output.
// RQ4: hold select low: output high only while activating reception continues.
// RQ5: reply enable high sends an acknowledgement after each accepted message.
// RQ6: bind request high starts the binding procedure between two units.
// RQ7: a press sequence on bind request restores factory defaults.
// RQ8: receive amplifier enable is high exactly while receiving.
// RQ9: low group direction low makes lines 0-3 outputs, high makes them inputs.
// RQ10: activity indicator flashes with on time encoding the current state.
// RQ11: host sends serial commands on the command input, holds it low if unused.
// RQ12: serial command responses go out on the command output line.
// RQ13: high group direction low makes lines 4-7 outputs, high makes them inputs.
// RQ14: transmit amplifier enable is high exactly while transmitting.
// RQ15: reply received goes high when an acknowledgement follows a sent message.
// RQ16: all level pins are synchronised to the clock before use.
module rcp_pin_logic #(
  parameter [15:0] MS_CYCLES = `RCP_MS_CYCLES,
  parameter [11:0] SEQ_WINDOW_MS = `RCP_SEQ_WINDOW_MS,
  parameter [2:0] FACTORY_PRESSES = `RCP_FACTORY_PRESSES
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_reset_n,
  input wire i_sleep_n,
  input wire i_hold_sel,
  input wire i_reply_en,
  input wire i_bind_req,
  input wire i_low_group_direction,
  input wire i_high_group_direction,
  input wire i_cmd_rx,
  input wire i_cmd_resp,
  input wire [`RCP_STATUS_WIDTH-1:0] i_status_lines,
  input wire i_radio_rx_on,
  input wire i_radio_tx_on,
  input wire i_rx_valid,
  input wire i_rx_active,
  input wire [`RCP_STATUS_WIDTH-1:0] i_rx_lines,
  input wire i_ctrl_sent,
  input wire i_ack_rcvd,
  input wire i_bind_done,
  output reg [`RCP_STATUS_WIDTH-1:0] o_status_lines,
  output reg [`RCP_STATUS_WIDTH-1:0] o_status_lines_oe,
  output reg [`RCP_STATUS_WIDTH-1:0] o_tx_lines,
  output reg o_rx_amp_enable,
  output reg o_tx_amp_enable,
  output reg o_activity_indicator,
  output reg o_cmd_tx,
  output reg o_cmd_rx_data,
  output reg o_ack_send,
  output reg o_bind_start,
  output reg o_binding,
  output reg o_factory_reset,
  output reg o_reply_rcvd,
  output reg o_running
);

  localparam [9:0] FLASH_PERIOD = `RCP_FLASH_PERIOD_MS;
  localparam [9:0] FLASH_IDLE = `RCP_FLASH_IDLE_MS;
  localparam [9:0] FLASH_ACTIVE = `RCP_FLASH_ACTIVE_MS;
  localparam [9:0] FLASH_BIND = `RCP_FLASH_BIND_MS;
  localparam [7:0] SY_RST_VAL = `RCP_SY_RST_VAL;

  // indicator states
  localparam [1:0] IND_IDLE = 2'b00;
  localparam [1:0] IND_ACTIVE = 2'b01;
  localparam [1:0] IND_BIND = 2'b10;

  wire [`RCP_SY_WIDTH-1:0] pins_raw;
  wire [`RCP_SY_WIDTH-1:0] pins;
  wire pin_reset_n;
  wire pin_awake;
  wire pin_hold;
  wire pin_reply;
  wire pin_bind;
  wire pin_low_dir;
  wire pin_high_dir;
  wire pin_cmd;

  reg [`RCP_STATUS_WIDTH-1:0] latched;
  reg [`RCP_STATUS_WIDTH-1:0] dir_in;
  reg awaiting_ack;
  reg bind_prev;
  reg [2:0] press_cnt;
  reg [11:0] win_ms;
  reg [15:0] tick_cnt;
  reg ms_tick;
  reg [9:0] flash_ms;
  reg [1:0] ind_state;
  reg [9:0] flash_on;
  reg [`RCP_STATUS_WIDTH-1:0] next_latched;

  assign pins_raw = {i_cmd_rx, i_high_group_direction, i_low_group_direction, i_bind_req,
                     i_reply_en, i_hold_sel, i_sleep_n, i_reset_n};

  rcp_sync #(
    .WIDTH(`RCP_SY_WIDTH),
    .RST_VAL(SY_RST_VAL)
  ) u_sync ( // RQ16
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  assign pin_reset_n = pins[`RCP_SY_RESET_N];
  assign pin_awake = pins[`RCP_SY_SLEEP_N];
  assign pin_hold = pins[`RCP_SY_HOLD];
  assign pin_reply = pins[`RCP_SY_REPLY];
  assign pin_bind = pins[`RCP_SY_BIND];
  assign pin_low_dir = pins[`RCP_SY_LOW_DIR];
  assign pin_high_dir = pins[`RCP_SY_HIGH_DIR];
  assign pin_cmd = pins[`RCP_SY_CMD];

  // per line direction: a set bit means the line is an input
  always @* begin
    dir_in = {{`RCP_GROUP_WIDTH{pin_high_dir}}, {`RCP_GROUP_WIDTH{pin_low_dir}}}; // RQ9 RQ13
  end

  // toggle every commanded line on each accepted message
  always @* begin
    next_latched = latched;
    if (i_rx_valid) begin
      next_latched = latched ^ i_rx_lines; // RQ3
    end
  end

  always @* begin
    ind_state = IND_IDLE;
    if (o_binding) begin
      ind_state = IND_BIND;
    end else if (i_radio_rx_on || i_radio_tx_on) begin
      ind_state = IND_ACTIVE;
    end
    case (ind_state)
      IND_IDLE: flash_on = FLASH_IDLE; // RQ10
      IND_ACTIVE: flash_on = FLASH_ACTIVE; // RQ10
      IND_BIND: flash_on = FLASH_BIND; // RQ10
      default: flash_on = FLASH_IDLE;
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status_lines <= 8'h00;
      o_status_lines_oe <= 8'h00;
      o_tx_lines <= 8'h00;
      o_rx_amp_enable <= 1'b0;
      o_tx_amp_enable <= 1'b0;
      o_activity_indicator <= 1'b0;
      o_cmd_tx <= 1'b0;
      o_cmd_rx_data <= 1'b0;
      o_ack_send <= 1'b0;
      o_bind_start <= 1'b0;
      o_binding <= 1'b0;
      o_factory_reset <= 1'b0;
      o_reply_rcvd <= 1'b0;
      o_running <= 1'b0;
      latched <= 8'h00;
      awaiting_ack <= 1'b0;
      bind_prev <= 1'b0;
      press_cnt <= 3'h0;
      win_ms <= 12'h000;
      tick_cnt <= 16'h0000;
      ms_tick <= 1'b0;
      flash_ms <= 10'h000;
    end else if (!pin_reset_n) begin
      // reset pin held low: back to the initial state
      o_status_lines <= 8'h00; // RQ1
      o_status_lines_oe <= 8'h00;
      o_tx_lines <= 8'h00;
      o_rx_amp_enable <= 1'b0;
      o_tx_amp_enable <= 1'b0;
      o_activity_indicator <= 1'b0;
      o_cmd_tx <= 1'b0;
      o_cmd_rx_data <= 1'b0;
      o_ack_send <= 1'b0;
      o_bind_start <= 1'b0;
      o_binding <= 1'b0;
      o_factory_reset <= 1'b0;
      o_reply_rcvd <= 1'b0;
      o_running <= 1'b0;
      latched <= 8'h00;
      awaiting_ack <= 1'b0;
      bind_prev <= 1'b0;
      press_cnt <= 3'h0;
      win_ms <= 12'h000;
      tick_cnt <= 16'h0000;
      ms_tick <= 1'b0;
      flash_ms <= 10'h000;
    end else if (!pin_awake) begin
      // low-power state: everything frozen, drivers and pulses off
      o_status_lines_oe <= 8'h00; // RQ2
      o_rx_amp_enable <= 1'b0;
      o_tx_amp_enable <= 1'b0;
      o_activity_indicator <= 1'b0;
      o_cmd_tx <= 1'b0;
      o_ack_send <= 1'b0;
      o_bind_start <= 1'b0;
      o_factory_reset <= 1'b0;
      o_running <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      o_running <= 1'b1;
      // status line drivers
      o_status_lines_oe <= ~dir_in; // RQ9 RQ13
      latched <= next_latched & ~dir_in;
      if (pin_hold) begin
        o_status_lines <= next_latched & ~dir_in; // RQ3
      end else begin
        o_status_lines <= (i_rx_active ? i_rx_lines : 8'h00) & ~dir_in; // RQ4
      end
      o_tx_lines <= i_status_lines & dir_in;
      // amplifiers follow the radio activity
      o_rx_amp_enable <= i_radio_rx_on; // RQ8
      o_tx_amp_enable <= i_radio_tx_on; // RQ14
      // serial command lines
      o_cmd_rx_data <= pin_cmd; // RQ11
      o_cmd_tx <= i_cmd_resp; // RQ12
      // acknowledgement of an accepted message
      o_ack_send <= i_rx_valid & pin_reply; // RQ5
      // reply received: arrival wins over the clear of a new message
      if (i_ctrl_sent) begin
        awaiting_ack <= 1'b1;
      end else if (i_ack_rcvd) begin
        awaiting_ack <= 1'b0;
      end
      if (i_ack_rcvd && awaiting_ack) begin
        o_reply_rcvd <= 1'b1; // RQ15
      end else if (i_ctrl_sent) begin
        o_reply_rcvd <= 1'b0;
      end
      // millisecond tick
      if (tick_cnt == MS_CYCLES - 16'h0001) begin
        tick_cnt <= 16'h0000;
        ms_tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
        ms_tick <= 1'b0;
      end
      // binding and factory default sequence
      bind_prev <= pin_bind;
      o_bind_start <= 1'b0;
      o_factory_reset <= 1'b0;
      if (pin_bind && !bind_prev) begin
        if (press_cnt == FACTORY_PRESSES - 3'h1) begin
          o_factory_reset <= 1'b1; // RQ7
          o_binding <= 1'b0;
          press_cnt <= 3'h0;
        end else begin
          o_bind_start <= 1'b1; // RQ6
          o_binding <= 1'b1; // RQ6
          press_cnt <= press_cnt + 3'h1;
          if (press_cnt == 3'h0) begin
            win_ms <= 12'h000;
          end
        end
      end else begin
        if (i_bind_done) begin
          o_binding <= 1'b0;
        end
        if (ms_tick && press_cnt != 3'h0) begin
          if (win_ms >= SEQ_WINDOW_MS - 12'h001) begin
            press_cnt <= 3'h0; // RQ7
          end else begin
            win_ms <= win_ms + 12'h001;
          end
        end
      end
      // activity indicator flash
      if (ms_tick) begin
        if (flash_ms == FLASH_PERIOD - 10'h001) begin
          flash_ms <= 10'h000;
        end else begin
          flash_ms <= flash_ms + 10'h001;
        end
      end
      o_activity_indicator <= (flash_ms < flash_on); // RQ10
    end
  end

endmodule // rcp_pin_logic

`default_nettype wire

// ===== testbench/rcp_pin_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rcp_pin_props (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_reset_n,
  input wire i_sleep_n,
  input wire i_bind_req,
  input wire i_low_group_direction,
  input wire i_high_group_direction,
  input wire i_cmd_resp,
  input wire i_radio_rx_on,
  input wire i_radio_tx_on,
  input wire i_rx_valid,
  input wire i_ack_rcvd,
  input wire [7:0] o_status_lines_oe,
  input wire o_rx_amp_enable,
  input wire o_tx_amp_enable,
  input wire o_cmd_tx,
  input wire o_ack_send,
  input wire o_bind_start,
  input wire o_binding,
  input wire o_factory_reset,
  input wire o_reply_rcvd,
  input wire o_running
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_rx_amp_copy: assert property (o_running && $past(o_running) |-> o_rx_amp_enable == $past(i_radio_rx_on))
    else $error("rx amp enable does not follow radio");
  a_tx_amp_copy: assert property (o_running && $past(o_running) |-> o_tx_amp_enable == $past(i_radio_tx_on))
    else $error("tx amp enable does not follow radio");
  a_cmd_out_copy: assert property (o_running && $past(o_running) |-> o_cmd_tx == $past(i_cmd_resp))
    else $error("command output does not follow response");
  a_low_group_input: assert property (i_low_group_direction [*5] ##0 o_running |->
    o_status_lines_oe[3:0] == 4'h0)
    else $error("low group driven while set as inputs");
  a_high_group_output: assert property ((!i_high_group_direction) [*5] ##0 (o_running && $past(o_running))
    |-> o_status_lines_oe[7:4] == 4'hF)
    else $error("high group not driven while set as outputs");
  a_reply_cause: assert property ($rose(o_reply_rcvd) |-> $past(i_ack_rcvd))
    else $error("reply flag rose without acknowledgement");
  a_ack_cause: assert property (o_ack_send |-> $past(i_rx_valid))
    else $error("ack request without accepted message");
  a_bind_edge: assert property (o_bind_start |-> o_binding && $past(i_bind_req, 3) && !$past(i_bind_req, 4))
    else $error("bind start not three cycles after press");
  a_factory_ends: assert property (o_factory_reset |=> !o_factory_reset && !o_binding)
    else $error("factory restore not a single pulse");
  a_reset_pin_clear: assert property ((!i_reset_n) [*4] |=>
    !o_running && !o_binding && o_status_lines_oe == 8'h00)
    else $error("reset pin low did not clear");
  a_sleep_stop: assert property ((!i_sleep_n) [*4] |=>
    !o_running && !o_tx_amp_enable && o_status_lines_oe == 8'h00)
    else $error("sleep did not stop outputs");
endmodule // rcp_pin_props
bind rcp_pin_logic rcp_pin_props u_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_sleep_n(i_sleep_n),
  .i_bind_req(i_bind_req), .i_low_group_direction(i_low_group_direction),
  .i_high_group_direction(i_high_group_direction), .i_cmd_resp(i_cmd_resp),
  .i_radio_rx_on(i_radio_rx_on), .i_radio_tx_on(i_radio_tx_on), .i_rx_valid(i_rx_valid),
  .i_ack_rcvd(i_ack_rcvd), .o_status_lines_oe(o_status_lines_oe), .o_rx_amp_enable(o_rx_amp_enable),
  .o_tx_amp_enable(o_tx_amp_enable), .o_cmd_tx(o_cmd_tx), .o_ack_send(o_ack_send),
  .o_bind_start(o_bind_start), .o_binding(o_binding), .o_factory_reset(o_factory_reset),
  .o_reply_rcvd(o_reply_rcvd), .o_running(o_running));
`default_nettype wire

// ===== testbench/rcp_remote.sv
`timescale 1ns/1ps
`default_nettype none
module rcp_remote (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_msg,
  input wire i_act,
  input wire [7:0] i_lines,
  input wire i_bind_start,
  output logic o_radio_rx_on,
  output logic o_rx_valid,
  output logic o_rx_active,
  output logic [7:0] o_rx_lines,
  output logic o_bind_done
);
  logic [3:0] bcnt;
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_radio_rx_on <= 1'h0;
      o_rx_valid <= 1'h0;
      o_rx_active <= 1'h0;
      o_rx_lines <= 8'h00;
      o_bind_done <= 1'h0;
      bcnt <= 4'h0;
    end else begin
      o_radio_rx_on <= i_msg | i_act;
      o_rx_valid <= i_msg;
      o_rx_active <= i_act;
      // lines carry no meaning outside a message or activation, so keep them moving
      o_rx_lines <= (i_msg | i_act) ? i_lines : ~o_rx_lines;
      bcnt <= i_bind_start ? 4'h8 : bcnt - {3'h0, bcnt != 4'h0};
      o_bind_done <= (bcnt == 4'h1);
    end
  end
endmodule // rcp_remote
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_core_clk = 0, i_rst = 1, i_reset_n = 1, i_sleep_n = 1, i_hold_sel = 1, i_reply_en = 1;
  logic i_bind_req = 0, i_low_group_direction = 0, i_high_group_direction = 0, i_cmd_rx = 0;
  logic i_cmd_resp = 0, i_radio_tx_on = 0, i_ctrl_sent = 0, i_ack_rcvd = 0, msg = 0, act = 0;
  logic [7:0] i_status_lines = 8'h00, lines = 8'h00;
  wire i_radio_rx_on, i_rx_valid, i_rx_active, i_bind_done, o_rx_amp_enable, o_tx_amp_enable;
  wire [7:0] i_rx_lines, o_status_lines, o_status_lines_oe, o_tx_lines;
  wire o_activity_indicator, o_cmd_tx, o_cmd_rx_data, o_ack_send;
  wire o_bind_start, o_binding, o_factory_reset, o_reply_rcvd, o_running;
  integer err_count = 0, num_checks = 0, fcnt = 0, bcnt = 0, icnt = 0, i0;
  always #12.5 i_core_clk = ~i_core_clk;
  rcp_pin_logic #(.MS_CYCLES(16'h0004), .SEQ_WINDOW_MS(12'h014)) dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_sleep_n(i_sleep_n),
    .i_hold_sel(i_hold_sel), .i_reply_en(i_reply_en), .i_bind_req(i_bind_req),
    .i_low_group_direction(i_low_group_direction), .i_high_group_direction(i_high_group_direction),
    .i_cmd_rx(i_cmd_rx), .i_cmd_resp(i_cmd_resp), .i_status_lines(i_status_lines),
    .i_radio_rx_on(i_radio_rx_on), .i_radio_tx_on(i_radio_tx_on), .i_rx_valid(i_rx_valid),
    .i_rx_active(i_rx_active), .i_rx_lines(i_rx_lines), .i_ctrl_sent(i_ctrl_sent),
    .i_ack_rcvd(i_ack_rcvd), .i_bind_done(i_bind_done), .o_status_lines(o_status_lines),
    .o_status_lines_oe(o_status_lines_oe), .o_tx_lines(o_tx_lines), .o_rx_amp_enable(o_rx_amp_enable),
    .o_tx_amp_enable(o_tx_amp_enable), .o_activity_indicator(o_activity_indicator), .o_cmd_tx(o_cmd_tx),
    .o_cmd_rx_data(o_cmd_rx_data), .o_ack_send(o_ack_send), .o_bind_start(o_bind_start),
    .o_binding(o_binding), .o_factory_reset(o_factory_reset), .o_reply_rcvd(o_reply_rcvd),
    .o_running(o_running));
  rcp_remote peer (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_msg(msg), .i_act(act), .i_lines(lines),
    .i_bind_start(o_bind_start), .o_radio_rx_on(i_radio_rx_on), .o_rx_valid(i_rx_valid),
    .o_rx_active(i_rx_active), .o_rx_lines(i_rx_lines), .o_bind_done(i_bind_done));
  always @(posedge i_core_clk) begin
    fcnt <= fcnt + o_factory_reset;
    bcnt <= bcnt + o_bind_start;
    icnt <= icnt + o_activity_indicator;
  end
  task tick(input integer n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task send(input logic [7:0] l);
    @(posedge i_core_clk) msg <= 1'h1;
    lines <= l;
    @(posedge i_core_clk) msg <= 1'h0;
    @(posedge i_core_clk) #1;
  endtask
  task press;
    @(posedge i_core_clk) i_bind_req <= 1'h1;
    tick(6);
    @(posedge i_core_clk) i_bind_req <= 1'h0;
    tick(6);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    tick(6);
    i_rst <= 1'h0;
    tick(6);
    #1 chk(o_running, 1);
    @(posedge i_core_clk) i_ack_rcvd <= 1'h1;
    @(posedge i_core_clk) i_ack_rcvd <= 1'h0;
    #1 chk(o_reply_rcvd, 0);
    send(8'h05);
    chk(o_ack_send, 1);
    chk(o_status_lines, 8'h05);
    chk(o_status_lines_oe, 8'hFF);
    send(8'h01);
    chk(o_status_lines, 8'h04);
    @(posedge i_core_clk) i_reply_en <= 1'h0;
    i_hold_sel <= 1'h0;
    tick(4);
    send(8'h10);
    chk(o_ack_send, 0);
    chk(o_status_lines, 8'h00);
    @(posedge i_core_clk) act <= 1'h1;
    lines <= 8'h02;
    tick(4);
    #1 chk(o_status_lines, 8'h02);
    @(posedge i_core_clk) act <= 1'h0;
    tick(3);
    #1 chk(o_status_lines, 8'h00);
    @(posedge i_core_clk) i_low_group_direction <= 1'h1;
    i_status_lines <= 8'hA5;
    tick(5);
    #1 chk(o_status_lines_oe, 8'hF0);
    chk(o_tx_lines, 8'h05);
    @(posedge i_core_clk) i_high_group_direction <= 1'h1;
    tick(5);
    #1 chk(o_status_lines_oe, 8'h00);
    chk(o_tx_lines, 8'hA5);
    @(posedge i_core_clk) i_low_group_direction <= 1'h0;
    i_high_group_direction <= 1'h0;
    i_radio_tx_on <= 1'h1;
    i_cmd_rx <= 1'h1;
    i_cmd_resp <= 1'h1;
    tick(5);
    #1 chk(o_tx_amp_enable, 1);
    chk(o_cmd_rx_data, 1);
    chk(o_cmd_tx, 1);
    @(posedge i_core_clk) i_radio_tx_on <= 1'h0;
    i_cmd_rx <= 1'h0;
    i_cmd_resp <= 1'h0;
    @(posedge i_core_clk) i_ctrl_sent <= 1'h1;
    @(posedge i_core_clk) i_ctrl_sent <= 1'h0;
    tick(2);
    @(posedge i_core_clk) i_ack_rcvd <= 1'h1;
    @(posedge i_core_clk) i_ack_rcvd <= 1'h0;
    #1 chk(o_reply_rcvd, 1);
    @(posedge i_core_clk) i_ctrl_sent <= 1'h1;
    @(posedge i_core_clk) i_ctrl_sent <= 1'h0;
    tick(1);
    #1 chk(o_reply_rcvd, 0);
    repeat (4) press();
    #1 chk(fcnt[7:0], 8'h01);
    chk(bcnt[7:0], 8'h03);
    repeat (3) press();
    tick(100);
    press();
    #1 chk(fcnt[7:0], 8'h01);
    chk(bcnt[7:0], 8'h07);
    tick(100);
    i0 = icnt;
    tick(4000);
    chk(16'(icnt - i0), 16'h00C8);
    @(posedge i_core_clk) i_radio_tx_on <= 1'h1;
    tick(10);
    i0 = icnt;
    tick(4000);
    chk(16'(icnt - i0), 16'h0320);
    i_radio_tx_on <= 1'h0;
    @(posedge i_core_clk) i_sleep_n <= 1'h0;
    tick(5);
    #1 chk(o_running, 0);
    chk(o_status_lines_oe, 8'h00);
    @(posedge i_core_clk) i_sleep_n <= 1'h1;
    i_hold_sel <= 1'h1;
    tick(5);
    send(8'h08);
    chk(o_status_lines, 8'h08);
    @(posedge i_core_clk) i_reset_n <= 1'h0;
    tick(5);
    #1 chk(o_status_lines, 8'h00);
    chk(o_running, 0);
    @(posedge i_core_clk) i_reset_n <= 1'h1;
    tick(5);
    #1 chk(o_running, 1);
    chk(o_status_lines_oe, 8'hFF);
    send(8'h01);
    chk(o_status_lines, 8'h01);
    report_and_stop();
  end
  initial begin
    #(25 * 20000);
    err_count++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
